/* File: hw/lcpwm_top.sv */
// led channel pwm generator, charge pump mode controller and power state
`timescale 1ns/1ps
module lcpwm_top #(
   parameter int IDLE_CYCLES = lcpwm_pkg::IDLE_CYC,
   parameter int WAKE_CYCLES = lcpwm_pkg::WAKE_CYC,
   parameter int SLOT_CYCLES = lcpwm_pkg::SLOT_CYC,
   parameter int SETTLE_CYCLES = lcpwm_pkg::SETTLE_CYC
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic WR_STB,
   input wire logic [lcpwm_pkg::CTRL_W-1:0] WR_CTRL,
   input wire logic [lcpwm_pkg::NUM_CH*lcpwm_pkg::DUTY_W-1:0] STAGED_DUTY,
   input wire logic [lcpwm_pkg::NUM_CH*lcpwm_pkg::LEVEL_W-1:0] STAGED_LEVEL,
   input wire logic [lcpwm_pkg::NUM_CH-1:0] STAGED_ENABLE,
   input wire logic BUS_ACTIVE,
   input wire logic [lcpwm_pkg::NUM_CH-1:0] REG_LOST,
   input wire logic [lcpwm_pkg::NUM_CH-1:0] X1_OK,
   output logic [lcpwm_pkg::NUM_CH-1:0] CH_ON,
   output logic [lcpwm_pkg::NUM_CH*lcpwm_pkg::DAC_W-1:0] CH_DAC,
   output lcpwm_pkg::lcpwm_mode_e PUMP_MODE,
   output logic LOW_POWER,
   output logic READY
);
   import lcpwm_pkg::*;
   if (IDLE_CYCLES < 1 || WAKE_CYCLES < 1 || SETTLE_CYCLES < 1) begin : g_bad_count
      $error("timing counts must be at least one");
   end
   // idle and wake counters are 24 bits, settle counter 16 bits
   if (WAKE_CYCLES >= 2**24 || IDLE_CYCLES >= 2**24 || SETTLE_CYCLES > 2**16) begin : g_bad_width
      $error("timing counts exceed counter width");
   end
   // ==========================================================
   // log current table: about 12 percent per step, 0 lowest, 31 full
   // one constant ratio end to end, so no step is brighter than its neighbours
   function automatic logic [DAC_W-1:0] log_level(input logic [LEVEL_W-1:0] code);
      logic [DAC_W-1:0] v;
      v = 16'h0000;
      case (code)
         5'h00: v = 16'h0740;
         5'h01: v = 16'h0822;
         5'h02: v = 16'h0920;
         5'h03: v = 16'h0a3c;
         5'h04: v = 16'h0b7c;
         5'h05: v = 16'h0ce2;
         5'h06: v = 16'h0e74;
         5'h07: v = 16'h1037;
         5'h08: v = 16'h1230;
         5'h09: v = 16'h1468;
         5'h0a: v = 16'h16e4;
         5'h0b: v = 16'h19ae;
         5'h0c: v = 16'h1ccf;
         5'h0d: v = 16'h2052;
         5'h0e: v = 16'h2442;
         5'h0f: v = 16'h28ad;
         5'h10: v = 16'h2da1;
         5'h11: v = 16'h3331;
         5'h12: v = 16'h396d;
         5'h13: v = 16'h406c;
         5'h14: v = 16'h4846;
         5'h15: v = 16'h5114;
         5'h16: v = 16'h5af5;
         5'h17: v = 16'h660a;
         5'h18: v = 16'h7279;
         5'h19: v = 16'h806c;
         5'h1a: v = 16'h9012;
         5'h1b: v = 16'ha19f;
         5'h1c: v = 16'hb551;
         5'h1d: v = 16'hcb68;
         5'h1e: v = 16'he431;
         5'h1f: v = 16'hffff;
         default: v = 16'h0740;
      endcase
      return v;
   endfunction
   // ==========================================================
   // apply staged settings
   lcpwm_if cfg ();
   logic [NUM_CH*DUTY_W-1:0] duty;
   logic [NUM_CH*LEVEL_W-1:0] level;
   logic [NUM_CH-1:0] enable;
   wire apply = WR_STB && (WR_CTRL == CTRL_APPLY || WR_CTRL == CTRL_WRITE_APPLY);
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         duty <= {NUM_CH{DUTY_RST}};
         level <= {NUM_CH{LEVEL_RST}};
         enable <= ENABLE_RST;
      end else if (apply) begin
         duty <= STAGED_DUTY;
         level <= STAGED_LEVEL;
         enable <= STAGED_ENABLE;
      end
   end
   assign cfg.duty = duty;
   assign cfg.enable = enable;
   // ==========================================================
   // power state
   lcpwm_pwr_e pwr, next_pwr;
   logic [23:0] idle_cnt;
   logic [23:0] wake_cnt;
   wire idle = (enable == '0) && !BUS_ACTIVE && !apply;
   wire idle_done = (idle_cnt == 24'(IDLE_CYCLES - 1));
   wire wake_done = (wake_cnt == 24'(WAKE_CYCLES - 1));
   always_comb begin
      next_pwr = pwr;
      case (pwr)
         LCPWM_RUN: if (idle && idle_done) next_pwr = LCPWM_SLEEP;
         LCPWM_SLEEP: if (BUS_ACTIVE || apply) next_pwr = LCPWM_RUN;
         default: next_pwr = LCPWM_RUN;
      endcase
   end
   always_ff @(posedge CLK) begin
      if (!RST_B) pwr <= LCPWM_RUN;
      else pwr <= next_pwr;
   end
   always_ff @(posedge CLK) begin
      if (!RST_B || pwr != LCPWM_RUN || !idle) idle_cnt <= '0;
      else if (!idle_done) idle_cnt <= idle_cnt + 24'h00_0001;
   end
   // wake settle counter; ready about WAKE_CYCLES after bus traffic, at the wake bound
   always_ff @(posedge CLK) begin
      if (!RST_B) wake_cnt <= 24'(WAKE_CYCLES - 1);
      else if (pwr == LCPWM_SLEEP) wake_cnt <= '0;
      else if (!wake_done) wake_cnt <= wake_cnt + 24'h00_0001;
   end
   wire run = (pwr == LCPWM_RUN);
   assign LOW_POWER = (pwr == LCPWM_SLEEP);
   assign READY = run && wake_done;
   // ==========================================================
   // pwm core
   logic [NUM_CH-1:0] pwm_on;
   lcpwm_core #(.SLOT_CYCLES(SLOT_CYCLES)) u_core (
      .clk(CLK),
      .rst_b(RST_B),
      .run(run),
      .cfg(cfg.dst),
      .pwm_on(pwm_on),
      .period_start()
   );
   assign CH_ON = pwm_on;
   // ==========================================================
   // dac codes
   always_ff @(posedge CLK) begin
      if (!RST_B) CH_DAC <= '0;
      else begin
         for (int i = 0; i < NUM_CH; i++) begin
            CH_DAC[i*DAC_W +: DAC_W] <= log_level(level[i*LEVEL_W +: LEVEL_W]);
         end
      end
   end
   // ==========================================================
   // pump mode: loss judged on active channels only, 1x on all enabled channels; settle time between moves
   wire [NUM_CH-1:0] active = enable & pwm_on;
   wire lost = |(REG_LOST & active);
   wire x1_all = &(X1_OK | ~enable);
   logic [15:0] settle;
   wire settled = (settle == 16'h0000);
   lcpwm_mode_e next_mode;
   always_comb begin
      next_mode = PUMP_MODE;
      if (!settled) next_mode = PUMP_MODE;
      else if (PUMP_MODE != LCPWM_X1 && x1_all) next_mode = LCPWM_X1;
      else if (lost) begin
         case (PUMP_MODE)
            LCPWM_X1: next_mode = LCPWM_X133;
            LCPWM_X133: next_mode = LCPWM_X15;
            LCPWM_X15: next_mode = LCPWM_X2;
            LCPWM_X2: next_mode = LCPWM_X2;
            default: next_mode = LCPWM_X1;
         endcase
      end
   end
   always_ff @(posedge CLK) begin
      if (!RST_B) PUMP_MODE <= LCPWM_X1;
      else if (!run) PUMP_MODE <= LCPWM_X1;
      else PUMP_MODE <= next_mode;
   end
   always_ff @(posedge CLK) begin
      if (!RST_B) settle <= '0;
      else if (next_mode != PUMP_MODE && run) settle <= 16'(SETTLE_CYCLES - 1);
      else if (!settled) settle <= settle - 16'h0001;
   end
   // ==========================================================
   // checks
   a_mode_reset: assert property (@(posedge CLK) !RST_B |=> PUMP_MODE == LCPWM_X1)
      else $error("pump mode not 1x after reset");
   a_mode_hold: assert property (@(posedge CLK) disable iff (!RST_B)
      (run && !lost && !x1_all) |=> PUMP_MODE == $past(PUMP_MODE))
      else $error("pump mode moved with good headroom");
   // one-hot codes: a single step up is a shift by one place
   a_mode_step: assert property (@(posedge CLK) disable iff (!RST_B)
      (PUMP_MODE != $past(PUMP_MODE) && PUMP_MODE != LCPWM_X1)
      |-> PUMP_MODE == ($past(PUMP_MODE) << 1))
      else $error("pump mode skipped a step");
   a_mode_drop: assert property (@(posedge CLK) disable iff (!RST_B)
      (run && settled && PUMP_MODE != LCPWM_X1 && x1_all) |=> PUMP_MODE == LCPWM_X1)
      else $error("pump mode did not drop to 1x");
   a_apply_only: assert property (@(posedge CLK) disable iff (!RST_B)
      !apply |=> enable == $past(enable) && duty == $past(duty))
      else $error("settings changed without apply");
   a_apply_load: assert property (@(posedge CLK) disable iff (!RST_B)
      apply |=> enable == $past(STAGED_ENABLE))
      else $error("enable not loaded on apply");
   a_wake_fast: assert property (@(posedge CLK) disable iff (!RST_B)
      (LOW_POWER && BUS_ACTIVE) |=> !LOW_POWER)
      else $error("no wake on bus traffic");
   a_sleep_idle: assert property (@(posedge CLK) disable iff (!RST_B)
      $rose(LOW_POWER) |-> $past(idle) && $past(idle_done))
      else $error("low power entered early");
   for (genvar k = 0; k < NUM_CH; k++) begin : g_dac_chk
      a_dac_full: assert property (@(posedge CLK) disable iff (!RST_B)
         level[k*LEVEL_W +: LEVEL_W] == 5'h1f |=> CH_DAC[k*DAC_W +: DAC_W] == 16'hffff)
         else $error("code 31 not full scale");
   end
   c_step_x2: cover property (@(posedge CLK) disable iff (!RST_B) PUMP_MODE == LCPWM_X2);
   c_sleep: cover property (@(posedge CLK) disable iff (!RST_B) $fell(LOW_POWER));
   c_apply: cover property (@(posedge CLK) disable iff (!RST_B) apply && STAGED_ENABLE != '0);
endmodule // lcpwm_top

/* File: hw/lcpwm_pkg.sv */
// package of constants and types for the led channel pwm and pump mode block
// How it works
// - eight channels, each own 6-bit duty
// - pwm period nominally 575 us
// - each channel holds 5-bit current code
// - current code mapped logarithmically to sink current
// - code 31 full scale, 0 lowest nonzero
// - pump mode starts at 1x
// - hold mode while headroom adequate
// - step up one mode on lost regulation
// - drop directly to 1x when 1x suffices
// - mode chosen from sensed headroom, no software
// - low power 5 ms after idle
// - wake within 1 ms on bus traffic
// - staged settings applied on control 000/010
// - apply switches channels per enable register
package lcpwm_pkg;
   // ==========================================================
   // sizes
   localparam int NUM_CH = 8;
   localparam int DUTY_W = 6;
   localparam int LEVEL_W = 5;
   localparam int DAC_W = 16;
   localparam int CTRL_W = 3;
   // ==========================================================
   // control codes
   localparam logic [2:0] CTRL_APPLY = 3'h0;
   localparam logic [2:0] CTRL_WRITE_APPLY = 3'h2;
   // ==========================================================
   // timing
   localparam int CLK_HZ = 125_000_000;
   localparam int PERIOD_NS = 575_000;
   localparam int CLK_NS = 8;
   localparam int SLOTS = 64;
   localparam int SLOT_CYC = PERIOD_NS / (CLK_NS * SLOTS);
   localparam int IDLE_MS = 5;
   localparam int IDLE_CYC = IDLE_MS * (CLK_HZ / 1000);
   localparam int WAKE_US = 1000;
   localparam int WAKE_CYC = WAKE_US * (CLK_HZ / 1_000_000);
   localparam int SETTLE_CYC = 256;
   // ==========================================================
   // reset values
   localparam logic [5:0] DUTY_RST = 6'h00;
   localparam logic [4:0] LEVEL_RST = 5'h00;
   localparam logic [7:0] ENABLE_RST = 8'h00;
   // ==========================================================
   // pump modes and power states
   typedef enum logic [3:0] {
      LCPWM_X1 = 4'b0001,
      LCPWM_X133 = 4'b0010,
      LCPWM_X15 = 4'b0100,
      LCPWM_X2 = 4'b1000
   } lcpwm_mode_e;
   typedef enum logic [1:0] {
      LCPWM_RUN = 2'b01,
      LCPWM_SLEEP = 2'b10
   } lcpwm_pwr_e;
endpackage

/* File: hw/lcpwm_if.sv */
// interface carrying the applied channel settings to the pwm core
`timescale 1ns/1ps
interface lcpwm_if;
   logic [lcpwm_pkg::NUM_CH*lcpwm_pkg::DUTY_W-1:0] duty;
   logic [lcpwm_pkg::NUM_CH-1:0] enable;
   modport src (output duty, output enable);
   modport dst (input duty, input enable);
endinterface

/* File: hw/lcpwm_core.sv */
// pwm slot counter and per-channel comparators
`timescale 1ns/1ps
module lcpwm_core #(
   parameter int SLOT_CYCLES = lcpwm_pkg::SLOT_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic run,
   lcpwm_if.dst cfg,
   output logic [lcpwm_pkg::NUM_CH-1:0] pwm_on,
   output logic period_start
);
   import lcpwm_pkg::*;
   // slot divider is 16 bits wide
   if (SLOT_CYCLES < 1 || SLOT_CYCLES > 2**16) begin : g_bad_slot
      $error("slot cycles must be between one and 65536");
   end
   logic [15:0] div;
   logic [DUTY_W-1:0] slot;
   logic [NUM_CH-1:0] next_pwm_on;
   wire div_end = (div == 16'(SLOT_CYCLES - 1));
   // ==========================================================
   // slot timebase
   always_ff @(posedge clk) begin
      if (!rst_b || !run) begin
         div <= '0;
         slot <= '0;
      end else begin
         div <= div_end ? 16'h0000 : div + 16'h0001;
         if (div_end) slot <= slot + 6'h01;
      end
   end
   assign period_start = div_end && (slot == 6'h3f);
   genvar g;
   for (g = 0; g < NUM_CH; g++) begin : g_cmp
      assign next_pwm_on[g] = run && cfg.enable[g] &&
         (slot < cfg.duty[g*DUTY_W +: DUTY_W]);
      // every channel is watched, not only the first
      a_pwm_off_zero: assert property (@(posedge clk) disable iff (!rst_b)
         (cfg.duty[g*DUTY_W +: DUTY_W] == 6'h00) |=> !pwm_on[g])
         else $error("channel on with zero duty");
      a_pwm_full_on: assert property (@(posedge clk) disable iff (!rst_b)
         (run && cfg.enable[g] && cfg.duty[g*DUTY_W +: DUTY_W] == 6'h3f && slot != 6'h3f)
         |=> pwm_on[g])
         else $error("channel off in active slot");
   end
   always_ff @(posedge clk) begin
      if (!rst_b) pwm_on <= '0;
      else pwm_on <= next_pwm_on;
   end
   c_pwm_period: cover property (@(posedge clk) disable iff (!rst_b) period_start);
endmodule // lcpwm_core

/* File: verification/lcpwm_host_model.sv */
// far-side model: register-file writer that stages settings and issues control codes
`timescale 1ns/1ps
module lcpwm_host_model (
   input wire logic clk,
   output logic wr_stb,
   output logic [2:0] wr_ctrl,
   output logic [47:0] staged_duty,
   output logic [39:0] staged_level,
   output logic [7:0] staged_enable,
   output logic bus_active
);
   logic bus_hold = 1'b1;
   initial begin
      wr_stb = 1'b0;
      wr_ctrl = 3'h1;
      staged_duty = 48'h0000_0000_0000;
      staged_level = 40'h00_0000_0000;
      staged_enable = 8'h00;
   end
   // traffic is seen at least while a command completes
   assign bus_active = bus_hold | wr_stb;
   // ==========================================================
   // register-file contents change only between commands
   task automatic stage(input logic [47:0] d, input logic [39:0] l, input logic [7:0] e);
      @(posedge clk);
      #1;
      staged_duty = d;
      staged_level = l;
      staged_enable = e;
   endtask
   task automatic cmd(input logic [2:0] c);
      @(posedge clk);
      #1;
      wr_ctrl = c;
      wr_stb = 1'b1;
      @(posedge clk);
      #1;
      wr_stb = 1'b0;
      // unqualified code shows garbage, not the last value
      wr_ctrl = ~c;
   endtask
endmodule // lcpwm_host_model

/* File: verification/led_channel_pwm_and_pump_mode_tb.sv */
// self-checking bench: staging, log levels, pwm duty, pump modes, low power
`timescale 1ns/1ps
module led_channel_pwm_and_pump_mode_tb;
   import lcpwm_pkg::*;
   localparam int SLOT = 2;
   localparam int IDLE = 50;
   localparam int WAKE = 10;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic wr_stb;
   logic [2:0] wr_ctrl;
   logic [47:0] s_duty;
   logic [39:0] s_level;
   logic [7:0] s_en;
   logic bus_active;
   logic [7:0] reg_lost = 8'h00;
   logic [7:0] x1_ok = 8'hff;
   logic [7:0] ch_on;
   logic [127:0] ch_dac;
   lcpwm_mode_e pump_mode;
   logic low_power;
   logic ready;
   int n_mismatch = 0;
   int n_compared = 0;
   logic [15:0] tab [32];
   logic [39:0] lv;
   logic [47:0] dv;
   int cnt [8];
   int r0;
   int r1;
   int exp_d [8] = '{0, 1, 63, 32, 17, 5, 0, 63};
   always #4 clk = ~clk;
   lcpwm_host_model lcpwm_host_model_i (.clk(clk), .wr_stb(wr_stb), .wr_ctrl(wr_ctrl),
      .staged_duty(s_duty), .staged_level(s_level), .staged_enable(s_en),
      .bus_active(bus_active));
   lcpwm_top #(.IDLE_CYCLES(IDLE), .WAKE_CYCLES(WAKE), .SLOT_CYCLES(SLOT), .SETTLE_CYCLES(4))
   lcpwm_top_i (.CLK(clk), .RST_B(rst_b), .WR_STB(wr_stb), .WR_CTRL(wr_ctrl),
      .STAGED_DUTY(s_duty), .STAGED_LEVEL(s_level), .STAGED_ENABLE(s_en),
      .BUS_ACTIVE(bus_active), .REG_LOST(reg_lost), .X1_OK(x1_ok), .CH_ON(ch_on),
      .CH_DAC(ch_dac), .PUMP_MODE(pump_mode), .LOW_POWER(low_power), .READY(ready));
   // ==========================================================
   // helpers
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic end_of_test;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic timed_out(input string msg);
      chk(1'b0, 1'b1, msg);
      end_of_test();
   endtask
   task automatic wait_mode(input lcpwm_mode_e exp);
      lcpwm_mode_e prev;
      int i;
      prev = pump_mode;
      for (i = 0; i < 40 && pump_mode === prev; i++) cyc(1);
      if (i == 40) timed_out("no mode change");
      chk(pump_mode, exp, "mode step");
   endtask
   task automatic count_on;
      foreach (cnt[c]) cnt[c] = 0;
      repeat (64 * SLOT) begin
         cyc(1);
         foreach (cnt[c]) cnt[c] += ch_on[c];
      end
   endtask
   // ==========================================================
   // sequence
   initial begin
      int i;
      cyc(5);
      rst_b = 1'b1;
      chk(pump_mode, LCPWM_X1, "reset mode");
      cyc(1);
      chk(ch_dac[15:0], 16'h0740, "code 0 after reset");
      lcpwm_host_model_i.stage({8{6'h3f}}, {8{5'h1f}}, 8'hff);
      for (int c = 1; c < 8; c++) if (c != 2) lcpwm_host_model_i.cmd(3'(c));
      cyc(3);
      chk(ch_on, 8'h00, "non-apply code drove outputs");
      chk(ch_dac[31:16], 16'h0740, "non-apply code changed level");
      $display("staging test done");
      for (int g = 0; g < 4; g++) begin
         for (int c = 0; c < 8; c++) lv[5*c+:5] = 5'(8 * g + c);
         lcpwm_host_model_i.stage(48'h0000_0000_0000, lv, 8'hff);
         lcpwm_host_model_i.cmd(g[0] ? CTRL_WRITE_APPLY : CTRL_APPLY);
         cyc(3);
         for (int c = 0; c < 8; c++) tab[8*g+c] = ch_dac[16*c+:16];
      end
      chk(tab[31], 16'hffff, "full scale code");
      chk(tab[0], 16'h0740, "zero scale code");
      for (int k = 1; k < 31; k++) begin
         chk(tab[k] > tab[k-1] && tab[k+1] - tab[k] >= tab[k] - tab[k-1], 1, "log step");
         // equal ratio per step, in parts per thousand
         r0 = int'(tab[k]) * 1000 / int'(tab[k-1]);
         r1 = int'(tab[k+1]) * 1000 / int'(tab[k]);
         chk(r1 - r0 <= 3 && r0 - r1 <= 3, 1, "log ratio");
      end
      $display("level table test done");
      dv = {6'd63, 6'd40, 6'd5, 6'd17, 6'd32, 6'd63, 6'd1, 6'd0};
      lcpwm_host_model_i.stage(dv, {8{5'h10}}, 8'hbf);
      lcpwm_host_model_i.cmd(CTRL_APPLY);
      cyc(3);
      count_on();
      foreach (cnt[c]) chk(cnt[c], exp_d[c] * SLOT, "on time per period");
      dv[18+:6] = 6'd8;
      lcpwm_host_model_i.stage(dv, {8{5'h10}}, 8'hbf);
      lcpwm_host_model_i.cmd(CTRL_WRITE_APPLY);
      cyc(3);
      count_on();
      chk(cnt[3], 8 * SLOT, "changed channel");
      chk(cnt[4], 17 * SLOT, "neighbour channel");
      $display("pwm test done");
      x1_ok = 8'h00;
      reg_lost = 8'h04;
      wait_mode(LCPWM_X133);
      wait_mode(LCPWM_X15);
      wait_mode(LCPWM_X2);
      cyc(40);
      chk(pump_mode, LCPWM_X2, "mode above 2x");
      // loss on a disabled channel must not move the pump
      reg_lost = 8'h40;
      cyc(40);
      chk(pump_mode, LCPWM_X2, "mode not held");
      x1_ok = 8'hbf;
      wait_mode(LCPWM_X1);
      reg_lost = 8'h00;
      x1_ok = 8'hff;
      $display("pump test done");
      lcpwm_host_model_i.stage(dv, {8{5'h10}}, 8'h00);
      lcpwm_host_model_i.cmd(CTRL_APPLY);
      lcpwm_host_model_i.bus_hold = 1'b0;
      cyc(IDLE - 10);
      chk(low_power, 1'b0, "slept early");
      for (i = 0; i < 20 && low_power !== 1'b1; i++) cyc(1);
      if (i == 20) timed_out("never slept");
      lcpwm_host_model_i.bus_hold = 1'b1;
      cyc(1);
      chk(low_power, 1'b0, "no wake on traffic");
      chk(ready, 1'b0, "ready before settle");
      for (i = 0; i < WAKE + 2 && ready !== 1'b1; i++) cyc(1);
      if (i == WAKE + 2) timed_out("wake too slow");
      $display("low power test done");
      end_of_test();
   end
endmodule // led_channel_pwm_and_pump_mode_tb
